// ===== tb/slswc_assertions.sv
// checker for the lane and sync word configuration outputs of the device end
// assumes the bench hands it the carrier signals and the device outputs by name
`timescale 1ns/10ps

module slswc_assertions (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr,
  input wire logic wr,
  input wire logic [7:0] lane_clk_en_o,
  input wire logic [7:0] ser_en_o,
  input wire logic [7:0] lane_ramp_o,
  input wire logic [3:0] lane_mode_o,
  input wire logic [3:0] lane_pattern_o,
  input wire logic sh_crc12_o,
  input wire logic sh_fec_o,
  input wire logic [slswc_pkg::SH_CMD_W-1:0] sh_cmd_o,
  input wire logic pll_on_o,
  input wire logic link_up_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // lanes the link mode asks for
  logic [7:0] req_mask;
  logic cfg_wr;
  assign req_mask = 8'hff >> (3'd7 - lane_mode_o[2:0]);
  // device write to the extra lane or sync word register
  assign cfg_wr = wr && addr inside {slswc_pkg::DEV_EXTRA_B, slswc_pkg::DEV_SYNC_MODE};

  // ----------------------------------------------------------------
  // lane gating
  // ----------------------------------------------------------------
  chk_gate_off: assert property (!link_up_o |-> (lane_clk_en_o | ser_en_o) == 8'h00)
    else $error("lanes active while link is down");
  chk_req_lanes: assert property (link_up_o |-> (req_mask & ~lane_clk_en_o) == '0)
    else $error("required lane clock missing");
  chk_ser_contig: assert property ((ser_en_o & 8'(ser_en_o + 8'h01)) == 8'h00)
    else $error("serializer enables not contiguous");
  chk_ser_in_clk: assert property ((ser_en_o & ~lane_clk_en_o) == 8'h00)
    else $error("serializer on without lane clock");
  chk_ramp_pat: assert property (|lane_ramp_o |-> lane_pattern_o inside {4'h0, 4'h5})
    else $error("ramp with wrong pattern");
  chk_ramp_extra: assert property ((lane_ramp_o & (req_mask | ~lane_clk_en_o)) == 8'h00)
    else $error("ramp on a required or idle lane");
  chk_pll_off: assert property (!pll_on_o |-> !link_up_o && lane_clk_en_o == 8'h00)
    else $error("lanes on with pll down");

  // ----------------------------------------------------------------
  // sync header and write ordering
  // ----------------------------------------------------------------
  chk_sync_enc: assert property (sh_crc12_o || sh_fec_o |-> lane_mode_o[3] && link_up_o)
    else $error("sync content outside 64b/66b");
  chk_sync_excl: assert property (!(sh_crc12_o && sh_fec_o))
    else $error("crc and fec both selected");
  chk_cmd_zero: assert property (sh_cmd_o == '0)
    else $error("command field not idle");
  chk_cfg_link_off: assert property (cfg_wr |-> ##2 !link_up_o)
    else $error("config written with link up");

  // main scenarios reached
  cov_ramp: cover property (lane_ramp_o != 8'h00);
  cov_fec: cover property (sh_fec_o);
  cov_ser3: cover property (ser_en_o[3]);
  cov_pll_off: cover property (!pll_on_o);
endmodule

// ===== tb/test_serial_link_lane_and_sync_word_config.sv
// self-checking bench: software port into the controller, device end behind it
// assumes one 125 mhz clock and the controller register map of the package
`timescale 1ns/10ps

module test_serial_link_lane_and_sync_word_config;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] sw_addr_i = 4'h0;
  logic [7:0] sw_wdata_i = 8'h00;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [7:0] sw_rdata_o, lane_clk_en_o, ser_en_o, lane_ramp_o, got;
  logic [3:0] lane_mode_o, lane_pattern_o;
  logic sh_crc12_o, sh_fec_o, pll_on_o, link_up_o;
  logic [slswc_pkg::SH_CMD_W-1:0] sh_cmd_o;
  int err_count = 0;
  int n_compared = 0;

  // ----------------------------------------------------------------
  // clock, ends and checker
  // ----------------------------------------------------------------
  always #4 mclk_i = ~mclk_i;
  slswc_link_if u_slswc_link_if ();
  slswc_host u_slswc_host (.mclk_i(mclk_i), .rst_i(rst_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .link(u_slswc_link_if.host));
  slswc_dev u_slswc_dev (.mclk_i(mclk_i), .rst_i(rst_i), .link(u_slswc_link_if.dev),
    .lane_clk_en_o(lane_clk_en_o), .ser_en_o(ser_en_o), .lane_ramp_o(lane_ramp_o),
    .lane_mode_o(lane_mode_o), .lane_pattern_o(lane_pattern_o), .sh_crc12_o(sh_crc12_o),
    .sh_fec_o(sh_fec_o), .sh_cmd_o(sh_cmd_o), .pll_on_o(pll_on_o), .link_up_o(link_up_o));
  slswc_assertions u_slswc_assertions (.mclk_i(mclk_i), .rst_i(rst_i),
    .addr(u_slswc_link_if.addr), .wr(u_slswc_link_if.wr), .lane_clk_en_o(lane_clk_en_o),
    .ser_en_o(ser_en_o), .lane_ramp_o(lane_ramp_o), .lane_mode_o(lane_mode_o),
    .lane_pattern_o(lane_pattern_o), .sh_crc12_o(sh_crc12_o), .sh_fec_o(sh_fec_o),
    .sh_cmd_o(sh_cmd_o), .pll_on_o(pll_on_o), .link_up_o(link_up_o));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge mclk_i);
    sw_wr_i <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge mclk_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask
  // lets a forwarded write reach the lane outputs
  task automatic settle();
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic set_link(input logic on);
    sw_write(slswc_pkg::H_LINK_EN, {7'h00, on});
  endtask
  task automatic readback(input logic [7:0] idx, input logic [7:0] e);
    sw_write(slswc_pkg::H_READBACK, idx);
    @(posedge mclk_i);
    sw_read(slswc_pkg::H_READBACK, got);
    cmp(got, e);
  endtask
  task automatic chk_lanes(input logic [7:0] c, input logic [7:0] s, input logic [7:0] r);
    cmp(lane_clk_en_o, c);
    cmp(ser_en_o, s);
    cmp(lane_ramp_o, r);
  endtask
  task automatic status_is(input logic [7:0] e);
    sw_read(slswc_pkg::H_STATUS, got);
    cmp(got, e);
    sw_write(slswc_pkg::H_STATUS, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk_lanes(8'h00, 8'h00, 8'h00);
    readback(8'h01, 8'h00);
    readback(8'h00, 8'h00);
    sw_write(4'hf, 8'hff);
    sw_read(4'hf, got);
    cmp(got, 8'h00);
  endtask
  task automatic t_extra_clk();
    sw_write(slswc_pkg::H_LINK_MODE, 8'h01);
    sw_write(slswc_pkg::H_EXTRA, 8'h08);
    set_link(1'b1);
    settle();
    chk_lanes(8'h0b, 8'h03, 8'h08);
    cmp({4'h0, lane_mode_o}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      sw_write(slswc_pkg::H_TEST_PAT, 8'(i));
      settle();
      cmp(lane_ramp_o, (i == 0 || i == 5) ? 8'h08 : 8'h00);
      cmp({4'h0, lane_pattern_o}, 8'(i));
    end
  endtask
  task automatic t_ser_force();
    set_link(1'b0);
    sw_write(slswc_pkg::H_TEST_PAT, 8'h00);
    sw_write(slswc_pkg::H_EXTRA, 8'h0d);
    set_link(1'b1);
    settle();
    chk_lanes(8'h0f, 8'h0f, 8'h0c);
    set_link(1'b0);
    sw_write(slswc_pkg::H_EXTRA, 8'h11);
    status_is(8'h01);
    readback(8'h00, 8'h0d);
  endtask
  task automatic t_link_on_refusal();
    set_link(1'b1);
    sw_write(slswc_pkg::H_SYNC, 8'h02);
    status_is(8'h01);
    sw_write(slswc_pkg::H_EXTRA, 8'h00);
    status_is(8'h01);
    readback(8'h00, 8'h0d);
    readback(8'h01, 8'h00);
  endtask
  task automatic t_sync();
    for (int c = 0; c < 5; c++) begin
      set_link(1'b0);
      sw_write(slswc_pkg::H_LINK_MODE, (c < 4) ? 8'h09 : 8'h01);
      sw_write(slswc_pkg::H_SYNC, 8'(c % 4));
      set_link(1'b1);
      settle();
      cmp({7'h00, sh_crc12_o}, {7'h00, c == 0});
      cmp({7'h00, sh_fec_o}, {7'h00, c == 2});
      cmp({1'b0, sh_cmd_o}, 8'h00);
    end
  endtask
  task automatic t_pd();
    logic [7:0] pd [3] = '{8'h02, 8'h03, 8'h01};
    for (int k = 0; k < 3; k++) begin
      set_link(1'b0);
      sw_write(slswc_pkg::H_CHAN_PD, pd[k]);
      set_link(1'b1);
      settle();
      cmp({7'h00, pll_on_o}, {7'h00, k != 1});
      cmp({7'h00, link_up_o}, {7'h00, k == 2});
      got = (k == 2) ? 8'h0f : 8'h00;
      chk_lanes(got, got, got & 8'h0c);
    end
  endtask
  // readback busy and ignored trigger, shadow reads, modes 0 and 7
  task automatic t_shadow();
    sw_write(slswc_pkg::H_READBACK, 8'h05);
    status_is(8'h02);
    sw_read(slswc_pkg::H_READBACK, got);
    cmp(got, 8'h01);
    sw_write(slswc_pkg::H_READBACK, 8'h03);
    sw_write(slswc_pkg::H_READBACK, 8'h04);
    @(posedge mclk_i);
    sw_read(slswc_pkg::H_READBACK, got);
    cmp(got, 8'h01);
    readback(8'h02, 8'h01);
    sw_read(slswc_pkg::H_CHAN_PD, got);
    cmp(got, 8'h01);
    sw_read(slswc_pkg::H_EXTRA, got);
    cmp(got, 8'h0d);
    sw_read(slswc_pkg::H_LINK_MODE, got);
    cmp(got, 8'h01);
    for (int m = 0; m < 2; m++) begin
      set_link(1'b0);
      sw_write(slswc_pkg::H_LINK_MODE, m ? 8'h07 : 8'h00);
      set_link(1'b1);
      settle();
      chk_lanes(m ? 8'hff : 8'h0d, m ? 8'hff : 8'h01, m ? 8'h00 : 8'h0c);
    end
  endtask

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    settle();
    t_reset();
    t_extra_clk();
    t_ser_force();
    t_link_on_refusal();
    t_sync();
    t_pd();
    t_shadow();
    print_verdict();
  end
endmodule

// ===== verilog/slswc_dev.sv
// device end: link-b extra lane and sync word configuration registers and lane gating
// assumes the controller honours the write ordering noted below
//
// Operation
// R1: extra lane bits 7:1 start lane link clocks
// R2: serializer bit also powers extra lane serializers
// R3: host writes extra lanes only with link off
// R4: extra lanes share link mode and rate
// R5: extra-only lanes send ramp on pattern 0/5
// R6: channel power-down overrides extra lane enables
// R7: serializer n clocked only if lanes below on
// R8: sync field selects content in 64b/66b only
// R9: code 0 crc-12, code 2 fec, others reserved
// R10: command fields of sync header always zero
// R11: host changes sync mode only with link off
// R12: both channels down powers whole link off
// R13: unrequested lanes keep clocks and serializers gated
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps

module slswc_dev (
  input wire logic mclk_i,
  input wire logic rst_i,
  slswc_link_if.dev link,
  output logic [7:0] lane_clk_en_o,
  output logic [7:0] ser_en_o,
  output logic [7:0] lane_ramp_o,
  output logic [3:0] lane_mode_o,
  output logic [3:0] lane_pattern_o,
  output logic sh_crc12_o,
  output logic sh_fec_o,
  output logic [slswc_pkg::SH_CMD_W-1:0] sh_cmd_o,
  output logic pll_on_o,
  output logic link_up_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic link_en;
    logic [3:0] link_mode;
    logic [1:0] chan_pd;
    logic [3:0] test_pat;
    logic [7:0] extra;
    logic [1:0] sync_mode;
    logic [7:0] rdata;
    logic [7:0] lane_clk;
    logic [7:0] ser_en;
    logic [7:0] ramp;
    logic [3:0] lane_mode;
    logic [3:0] lane_pat;
    logic sh_crc;
    logic sh_fec;
    logic [slswc_pkg::SH_CMD_W-1:0] sh_cmd;
    logic pll_on;
    logic link_up;
  } slswc_dev_st_t;

  slswc_dev_st_t state_ff;
  slswc_dev_st_t nxt_state;

  logic [7:0] req_m;
  logic [7:0] extra_m;
  logic [7:0] clk_m;
  logic [7:0] want_m;
  logic [7:0] ser_m;
  logic [7:0] ramp_m;
  logic pll_ok;
  logic up;
  logic tp_ramp;
  logic enc_66;

  // ----------------------------------------------------------------
  // lane gating terms
  // ----------------------------------------------------------------
  // subsystem power and link-b availability
  assign pll_ok = ~(&state_ff.chan_pd); // [R12]
  assign up = state_ff.link_en & pll_ok & ~state_ff.chan_pd[slswc_pkg::PD_CHB_BIT]; // [R6]
  assign req_m = slswc_pkg::slswc_req_mask(state_ff.link_mode[2:0]);
  assign tp_ramp = (state_ff.test_pat == slswc_pkg::TP_NONE) |
                   (state_ff.test_pat == slswc_pkg::TP_RAMP_ALIAS); // [R5]
  assign enc_66 = state_ff.link_mode[slswc_pkg::LM_ENC_BIT];

  // per-lane clock, serializer and ramp selection
  generate
    for (genvar g = 0; g < slswc_pkg::NUM_LANES; g++) begin : g_lane
      if (g == 0) begin : g_first
        // bit 0 holds the serializer force, lane 0 has no extra flag
        assign extra_m[g] = 1'b0;
        assign ser_m[g] = want_m[g];
      end else begin : g_rest
        assign extra_m[g] = state_ff.extra[g]; // [R1]
        // serializer clock passes only through a contiguous chain from lane 0
        assign ser_m[g] = want_m[g] & ser_m[g-1]; // [R7]
      end
      // link clock for required or extra lanes, else gated off
      assign clk_m[g] = up & (req_m[g] | extra_m[g]); // [R1] [R13]
      // extra lanes get a serializer only with the force bit set
      assign want_m[g] = up & (req_m[g] |
                         (extra_m[g] & state_ff.extra[slswc_pkg::EXTRA_SER_BIT])); // [R2] [R13]
      // lanes enabled only by the extra bits send the octet ramp
      assign ramp_m[g] = clk_m[g] & extra_m[g] & ~req_m[g] & tp_ramp; // [R5]
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // register writes, one-cycle read data and derived lane controls
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = slswc_pkg::RST_BYTE;
    // writes land whenever they come; ordering against link enable is
    // the controller's duty
    if (link.wr) begin // [R3] [R11]
      case (link.addr)
        slswc_pkg::DEV_LINK_EN: begin
          nxt_state.link_en = link.wdata[0];
        end
        slswc_pkg::DEV_LINK_MODE: begin
          nxt_state.link_mode = link.wdata[3:0];
        end
        slswc_pkg::DEV_CHAN_PD: begin
          nxt_state.chan_pd = link.wdata[1:0];
        end
        slswc_pkg::DEV_TEST_PAT: begin
          nxt_state.test_pat = link.wdata[3:0];
        end
        slswc_pkg::DEV_EXTRA_B: begin
          nxt_state.extra = link.wdata;
        end
        slswc_pkg::DEV_SYNC_MODE: begin
          nxt_state.sync_mode = link.wdata[1:0];
        end
        default: begin
          nxt_state.rdata = slswc_pkg::RST_BYTE;
        end
      endcase
    end
    // read data stands in the following cycle only, reserved bits zero
    if (link.rd) begin
      case (link.addr)
        slswc_pkg::DEV_LINK_EN: begin
          nxt_state.rdata = {7'h00, state_ff.link_en};
        end
        slswc_pkg::DEV_LINK_MODE: begin
          nxt_state.rdata = {4'h0, state_ff.link_mode};
        end
        slswc_pkg::DEV_CHAN_PD: begin
          nxt_state.rdata = {6'h00, state_ff.chan_pd};
        end
        slswc_pkg::DEV_TEST_PAT: begin
          nxt_state.rdata = {4'h0, state_ff.test_pat};
        end
        slswc_pkg::DEV_EXTRA_B: begin
          nxt_state.rdata = state_ff.extra;
        end
        slswc_pkg::DEV_SYNC_MODE: begin
          nxt_state.rdata = {6'h00, state_ff.sync_mode};
        end
        default: begin
          nxt_state.rdata = slswc_pkg::RST_BYTE; // unmapped reads zero
        end
      endcase
    end
    // lane controls follow the stored configuration one cycle later
    nxt_state.lane_clk = clk_m;
    nxt_state.ser_en = ser_m;
    nxt_state.ramp = ramp_m;
    // every active lane shares the selected mode and rate
    nxt_state.lane_mode = state_ff.link_mode; // [R4]
    nxt_state.lane_pat = state_ff.test_pat; // [R4]
    nxt_state.pll_on = pll_ok; // [R12]
    nxt_state.link_up = up;
    // sync word content only matters in 64b/66b modes
    nxt_state.sh_crc = up & enc_66 & (state_ff.sync_mode == slswc_pkg::SYNC_CRC12); // [R8] [R9]
    nxt_state.sh_fec = up & enc_66 & (state_ff.sync_mode == slswc_pkg::SYNC_FEC); // [R8] [R9]
    // no command channel: idle headers only
    nxt_state.sh_cmd = '0; // [R10]
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // synchronous reset clears all configuration
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output straight from the state register
  assign link.rdata = state_ff.rdata;
  assign lane_clk_en_o = state_ff.lane_clk;
  assign ser_en_o = state_ff.ser_en;
  assign lane_ramp_o = state_ff.ramp;
  assign lane_mode_o = state_ff.lane_mode;
  assign lane_pattern_o = state_ff.lane_pat;
  assign sh_crc12_o = state_ff.sh_crc;
  assign sh_fec_o = state_ff.sh_fec;
  assign sh_cmd_o = state_ff.sh_cmd;
  assign pll_on_o = state_ff.pll_on;
  assign link_up_o = state_ff.link_up;

endmodule

// ===== verilog/slswc_host.sv
// controller end: software orders land in shadow registers and are forwarded to the device
// assumes the software port follows single-cycle strobes, read data one cycle later
`timescale 1ns/10ps

module slswc_host (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [3:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  slswc_link_if.host link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    slswc_pkg::slswc_hfsm_t fsm;
    logic [7:0] extra;
    logic [1:0] sync;
    logic link_en;
    logic [3:0] mode;
    logic [3:0] pat;
    logic [1:0] pd;
    logic refused;
    logic [7:0] readback;
    logic [11:0] dev_addr;
    logic [7:0] dev_wdata;
    logic dev_wr;
    logic dev_rd;
    logic [7:0] sw_rdata;
  } slswc_hst_st_t;

  slswc_hst_st_t state_ff;
  slswc_hst_st_t nxt_state;
  logic [7:0] lanes;
  logic contig;

  // lanes in use after the write, must run from lane 0 without holes
  assign lanes = {sw_wdata_i[7:1], 1'b1} | slswc_pkg::slswc_req_mask(state_ff.mode[2:0]);
  assign contig = ((lanes & 8'(lanes + 8'h01)) == 8'h00); // [R7]

  // device address for a readback index
  function automatic logic [11:0] slswc_idx_addr(input logic [2:0] idx);
    case (idx)
      3'h0: slswc_idx_addr = slswc_pkg::DEV_EXTRA_B;
      3'h1: slswc_idx_addr = slswc_pkg::DEV_SYNC_MODE;
      3'h2: slswc_idx_addr = slswc_pkg::DEV_LINK_EN;
      3'h3: slswc_idx_addr = slswc_pkg::DEV_LINK_MODE;
      3'h4: slswc_idx_addr = slswc_pkg::DEV_TEST_PAT;
      default: slswc_idx_addr = slswc_pkg::DEV_CHAN_PD;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // software decode, refusal checks, device write and read sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_state.dev_wr = 1'b0;
    nxt_state.dev_rd = 1'b0;
    nxt_state.sw_rdata = slswc_pkg::RST_BYTE;
    if (sw_rd_i) begin
      case (sw_addr_i)
        slswc_pkg::H_EXTRA: nxt_state.sw_rdata = state_ff.extra;
        slswc_pkg::H_SYNC: nxt_state.sw_rdata = {6'h00, state_ff.sync};
        slswc_pkg::H_LINK_EN: nxt_state.sw_rdata = {7'h00, state_ff.link_en};
        slswc_pkg::H_LINK_MODE: nxt_state.sw_rdata = {4'h0, state_ff.mode};
        slswc_pkg::H_TEST_PAT: nxt_state.sw_rdata = {4'h0, state_ff.pat};
        slswc_pkg::H_CHAN_PD: nxt_state.sw_rdata = {6'h00, state_ff.pd};
        slswc_pkg::H_STATUS: nxt_state.sw_rdata = {6'h00, (state_ff.fsm != slswc_pkg::H_IDLE),
                                                   state_ff.refused};
        slswc_pkg::H_READBACK: nxt_state.sw_rdata = state_ff.readback;
        default: nxt_state.sw_rdata = slswc_pkg::RST_BYTE;
      endcase
    end
    // status clear goes first so a refusal in the same cycle still sets
    if (sw_wr_i && sw_addr_i == slswc_pkg::H_STATUS && sw_wdata_i[slswc_pkg::ST_REFUSED_BIT]) begin
      nxt_state.refused = 1'b0;
    end
    if (sw_wr_i) begin
      nxt_state.dev_wdata = sw_wdata_i;
      case (sw_addr_i)
        slswc_pkg::H_EXTRA: begin
          // link must be off, channel b up and, with the serializer bit set, lanes contiguous
          if (state_ff.link_en || state_ff.pd[slswc_pkg::PD_CHB_BIT] ||
              (sw_wdata_i[slswc_pkg::EXTRA_SER_BIT] && !contig)) begin // [R3] [R6] [R7]
            nxt_state.refused = 1'b1;
          end else begin
            nxt_state.extra = sw_wdata_i;
            nxt_state.dev_addr = slswc_pkg::DEV_EXTRA_B;
            nxt_state.dev_wr = 1'b1;
          end
        end
        slswc_pkg::H_SYNC: begin
          if (state_ff.link_en) begin // [R11]
            nxt_state.refused = 1'b1;
          end else begin
            nxt_state.sync = sw_wdata_i[1:0];
            nxt_state.dev_addr = slswc_pkg::DEV_SYNC_MODE;
            nxt_state.dev_wr = 1'b1;
          end
        end
        slswc_pkg::H_LINK_EN: begin
          nxt_state.link_en = sw_wdata_i[0];
          nxt_state.dev_addr = slswc_pkg::DEV_LINK_EN;
          nxt_state.dev_wr = 1'b1;
        end
        slswc_pkg::H_LINK_MODE: begin
          nxt_state.mode = sw_wdata_i[3:0];
          nxt_state.dev_addr = slswc_pkg::DEV_LINK_MODE;
          nxt_state.dev_wr = 1'b1;
        end
        slswc_pkg::H_TEST_PAT: begin
          nxt_state.pat = sw_wdata_i[3:0];
          nxt_state.dev_addr = slswc_pkg::DEV_TEST_PAT;
          nxt_state.dev_wr = 1'b1;
        end
        slswc_pkg::H_CHAN_PD: begin
          if (state_ff.link_en) begin // [R6]
            nxt_state.refused = 1'b1;
          end else begin
            nxt_state.pd = sw_wdata_i[1:0];
            nxt_state.dev_addr = slswc_pkg::DEV_CHAN_PD;
            nxt_state.dev_wr = 1'b1;
          end
        end
        slswc_pkg::H_READBACK: begin
          if (state_ff.fsm == slswc_pkg::H_IDLE) begin
            nxt_state.dev_addr = slswc_idx_addr(sw_wdata_i[2:0]);
            nxt_state.dev_rd = 1'b1;
            nxt_state.fsm = slswc_pkg::H_RD_ISSUE;
          end
        end
        default: begin
          nxt_state.dev_wr = 1'b0;
        end
      endcase
    end
    // read sequencer: strobe, then capture the byte one cycle later
    case (state_ff.fsm)
      slswc_pkg::H_IDLE: begin
      end
      slswc_pkg::H_RD_ISSUE: begin
        nxt_state.fsm = slswc_pkg::H_RD_CAPT;
      end
      slswc_pkg::H_RD_CAPT: begin
        nxt_state.readback = link.rdata;
        nxt_state.fsm = slswc_pkg::H_IDLE;
      end
      default: begin
        nxt_state.fsm = slswc_pkg::H_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // synchronous reset, all shadows zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign sw_rdata_o = state_ff.sw_rdata;
  assign link.addr = state_ff.dev_addr;
  assign link.wdata = state_ff.dev_wdata;
  assign link.wr = state_ff.dev_wr;
  assign link.rd = state_ff.dev_rd;

endmodule

// ===== verilog/slswc_link_if.sv
// register access carrier between the controller and the device
// assumes the controller drives every request signal right after a clock edge
`timescale 1ns/10ps

interface slswc_link_if;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;

  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata
  );
endinterface

// ===== verilog/slswc_pkg.sv
// shared constants and types for the link-b lane and sync word configuration
// assumes both ends run on one 125 mhz clock with a synchronous active-high reset

package slswc_pkg;

  // ----------------------------------------------------------------
  // widths and lane count
  // ----------------------------------------------------------------
  localparam int NUM_LANES = 8;
  localparam int SH_CMD_W = 7;

  // ----------------------------------------------------------------
  // device register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] DEV_LINK_EN = 12'h200;
  localparam logic [11:0] DEV_LINK_MODE = 12'h201;
  localparam logic [11:0] DEV_CHAN_PD = 12'h202;
  localparam logic [11:0] DEV_TEST_PAT = 12'h206;
  localparam logic [11:0] DEV_EXTRA_B = 12'h20b;
  localparam logic [11:0] DEV_SYNC_MODE = 12'h20f;

  // ----------------------------------------------------------------
  // field positions, codes and reset values
  // ----------------------------------------------------------------
  localparam int EXTRA_SER_BIT = 0;
  localparam int LM_ENC_BIT = 3;
  localparam int PD_CHB_BIT = 1;
  localparam int ST_REFUSED_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam logic [1:0] SYNC_CRC12 = 2'h0;
  localparam logic [1:0] SYNC_FEC = 2'h2;
  localparam logic [3:0] TP_NONE = 4'h0;
  localparam logic [3:0] TP_RAMP = 4'h4;
  localparam logic [3:0] TP_RAMP_ALIAS = 4'h5;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // controller register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] H_EXTRA = 4'h0;
  localparam logic [3:0] H_SYNC = 4'h1;
  localparam logic [3:0] H_LINK_EN = 4'h2;
  localparam logic [3:0] H_LINK_MODE = 4'h3;
  localparam logic [3:0] H_TEST_PAT = 4'h4;
  localparam logic [3:0] H_CHAN_PD = 4'h5;
  localparam logic [3:0] H_STATUS = 4'h6;
  localparam logic [3:0] H_READBACK = 4'h7;

  // controller read sequencer states
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_RD_ISSUE = 2'b01,
    H_RD_CAPT = 2'b10
  } slswc_hfsm_t;

  // lanes needed by a link mode: lanes 0 to cnt_m1
  function automatic logic [7:0] slswc_req_mask(input logic [2:0] cnt_m1);
    slswc_req_mask = 8'hff >> (3'd7 - cnt_m1);
  endfunction

endpackage
